// ===== rtl/ppbd_pkg.sv
/*
  constants, entry layouts, state types and the image decode function of the
  processor-to-pci bridge datapath.
  assumes every user of it names items as ppbd_pkg::name, never by import.
*/
// Operation
// - write posted or delayed per image setting
// - posted write: queue, acknowledge at once, later
// - delayed read prefetches; later reads use queue
// - delayed access acknowledged after pci acknowledge
// - two processor images reach memory or io
// - configuration only through config data window
// - claim cycle only with chip select asserted
// - inbound posted writes in 256-byte queue
// - delayed pci access completes on processor first
// - pci reads delayed; prefetch into 256-byte queue
// - two pci images placed in memory/io
// - outbound posted queue: 64 words, fill while draining
// - outbound read queue holds 32 bytes
// - delayed write finishes before next posted write
// - image select low image 0, high image 1
package ppbd_pkg;

  // ************************************************************
  // queue sizes, in 32-bit words
  // ************************************************************
  localparam int OPWQ_DEPTH = 64; // 256 bytes outbound posted
  localparam int ORQ_DEPTH = 8; // 32 bytes outbound read
  localparam int IPWQ_DEPTH = 64; // 256 bytes inbound posted
  localparam int IPQ_DEPTH = 64; // 256 bytes inbound prefetch
  localparam int OBUF_DEPTH = 2; // skid buffer toward the pci master

  // ************************************************************
  // burst lengths, address step, counters
  // ************************************************************
  localparam logic [3:0] ORQ_LEN = 4'h8; // outbound prefetch burst
  localparam logic [3:0] CFG_LEN = 4'h1; // config access is single
  localparam logic [6:0] IPQ_LEN = 7'h40; // inbound prefetch burst
  localparam logic [6:0] SINGLE_LEN = 7'h01; // inbound single read
  localparam logic [3:0] OB_LAST = 4'h1;
  localparam logic [6:0] IB_LAST = 7'h01;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [7:0] WCNT_ONE = 8'h01;
  localparam logic [31:0] TIMG_MASK = 32'hffff_0000; // 64 kbyte windows

  // ************************************************************
  // pci command kinds
  // ************************************************************
  localparam logic [1:0] CMD_MEM = 2'h0;
  localparam logic [1:0] CMD_IO = 2'h1;
  localparam logic [1:0] CMD_CFG = 2'h2;

  // ************************************************************
  // entry layouts and states
  // ************************************************************
  typedef struct packed {
    logic dly; // delayed write marker
    logic [1:0] cmd;
    logic [31:0] addr;
    logic [31:0] data;
  } ppbd_owe_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } ppbd_iwe_s;

  typedef enum logic [1:0] {
    OB_IDLE = 2'b00,
    OB_RDWAIT = 2'b01,
    OB_DWWAIT = 2'b11
  } ppbd_ob_e;

  typedef enum logic {
    IB_IDLE = 1'b0,
    IB_RDWAIT = 1'b1
  } ppbd_ib_e;

  // pci target image decode, used for both images
  function automatic logic ppbd_img_hit(input logic [31:0] addr, input logic [31:0] base,
                                        input logic img_io, input logic req_io);
    ppbd_img_hit = ((addr & TIMG_MASK) == (base & TIMG_MASK)) && (img_io == req_io);
  endfunction

endpackage

// ===== rtl/ppbd_q_if.sv
/*
  push/pop carrier between the datapath and its queues.
  assumes both sides run on the same clock; flush is a one-cycle pulse.
*/
`timescale 1ns/1ps
interface ppbd_q_if #(parameter int W = 32);
  logic push_valid; // filler offers a word
  logic push_ready; // queue has room
  logic [W-1:0] push_data;
  logic pop_valid; // head word present
  logic pop_ready; // drainer takes the head
  logic [W-1:0] pop_data;
  logic flush; // drop all contents
  modport queue(input push_valid, push_data, pop_ready, flush,
                output push_ready, pop_valid, pop_data);
  modport user(output push_valid, push_data, pop_ready, flush,
               input push_ready, pop_valid, pop_data);
endinterface

// ===== rtl/ppbd_queue.sv
/*
  synchronous queue with a registered head, DEPTH words of W bits.
  assumes DEPTH is a power of two; flush and srst win over a push.
*/
`timescale 1ns/1ps
module ppbd_queue #(
  parameter int DEPTH = 2,
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic srst,
  ppbd_q_if.queue q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  logic [W-1:0] mem_reg [DEPTH]; // storage, no reset needed
  logic [AW-1:0] rptr_reg;
  logic [AW-1:0] wptr_reg;
  logic [AW:0] count_reg;
  logic pop_valid_reg;
  logic [W-1:0] pop_data_reg;

  // ************************************************************
  // next-state decode
  // ************************************************************
  wire do_push = q.push_valid && q.push_ready;
  wire do_pop = q.pop_valid && q.pop_ready;
  wire [AW:0] count_next = count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
  wire [AW-1:0] rptr_next = rptr_reg + AW'(do_pop);
  // bypass: a word pushed into an empty queue is the next head
  wire [W-1:0] head_next = (do_push && rptr_next == wptr_reg) ? q.push_data
                                                              : mem_reg[rptr_next];
  assign q.push_ready = (count_reg != CNT_FULL); // honest full
  assign q.pop_valid = pop_valid_reg;
  assign q.pop_data = pop_data_reg;

  // pointers and count; fill and drain may share a cycle
  always_ff @(posedge clk) begin
    if (srst || q.flush) begin
      rptr_reg <= '0;
      wptr_reg <= '0;
      count_reg <= '0;
      pop_valid_reg <= 1'b0;
      pop_data_reg <= '0;
    end else begin
      rptr_reg <= rptr_next;
      wptr_reg <= wptr_reg + AW'(do_push);
      count_reg <= count_next;
      pop_valid_reg <= (count_next != '0);
      pop_data_reg <= head_next;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wptr_reg] <= q.push_data;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_fill_drain;
    do_push && do_pop && !q.flush |=> count_reg == $past(count_reg);
  endproperty
  a_fill_drain: assert property (p_fill_drain) else $error("count moved on push+pop");

  property p_flush_empty;
    q.flush |=> !q.pop_valid && count_reg == '0 && q.push_ready;
  endproperty
  a_flush_empty: assert property (p_flush_empty) else $error("flush left data");

  property p_first_word;
    do_push && count_reg == '0 && !q.flush |=> q.pop_valid && q.pop_data == $past(q.push_data);
  endproperty
  a_first_word: assert property (p_first_word) else $error("head not the pushed word");

  cover property (count_reg == CNT_FULL);
endmodule

// ===== rtl/ppbd_top.sv
/*
  transaction datapath between a processor bus slave port and pci master and
  target ports: posted, delayed and prefetched traffic in both directions.
  assumes every input is synchronous to REF_CLK, a requester holds its
  request until the acknowledge, and pci data returns in order.
*/
`timescale 1ns/1ps
module ppbd_top (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic QB_REQ,
  input wire logic QB_BRIDGE_CHIP_SELECT_N,
  input wire logic QB_CONFIG_DATA_WINDOW,
  input wire logic QB_IMAGE_SELECT,
  input wire logic QB_WR,
  input wire logic [31:0] QB_ADDR,
  input wire logic [31:0] QB_WDATA,
  output logic QB_ACK,
  output logic [31:0] QB_RDATA,
  input wire logic [1:0] IMG_POSTED,
  input wire logic [1:0] IMG_IO,
  output logic PM_WVALID,
  input wire logic PM_WREADY,
  output logic [1:0] PM_WCMD,
  output logic [31:0] PM_WADDR,
  output logic [31:0] PM_WDATA,
  input wire logic PM_WACK,
  output logic PM_RREQ,
  output logic [1:0] PM_RCMD,
  output logic [31:0] PM_RADDR,
  output logic [3:0] PM_RLEN,
  input wire logic PM_RVALID,
  input wire logic [31:0] PM_RDATA,
  input wire logic PT_REQ,
  input wire logic PT_WR,
  input wire logic PT_IO,
  input wire logic [31:0] PT_ADDR,
  input wire logic [31:0] PT_WDATA,
  output logic PT_ACK,
  output logic [31:0] PT_RDATA,
  input wire logic [31:0] TIMG_BASE0,
  input wire logic [31:0] TIMG_BASE1,
  input wire logic [1:0] TIMG_IO,
  input wire logic [1:0] TIMG_PREF,
  output logic QM_WVALID,
  input wire logic QM_WREADY,
  output logic [31:0] QM_WADDR,
  output logic [31:0] QM_WDATA,
  output logic QM_RREQ,
  output logic [31:0] QM_RADDR,
  output logic [6:0] QM_RLEN,
  input wire logic QM_RVALID,
  input wire logic [31:0] QM_RDATA
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  localparam int OW = $bits(ppbd_pkg::ppbd_owe_s);
  localparam int IW = $bits(ppbd_pkg::ppbd_iwe_s);

  // ************************************************************
  // queues
  // ************************************************************
  ppbd_q_if #(.W(OW)) outbound_posted_write_queue();
  ppbd_q_if #(.W(OW)) obuf(); // two-entry skid toward pci
  ppbd_q_if #(.W(32)) outbound_read_queue();
  ppbd_q_if #(.W(IW)) inbound_posted_write_queue();
  ppbd_q_if #(.W(32)) inbound_prefetch_queue();

  ppbd_queue #(.DEPTH(ppbd_pkg::OPWQ_DEPTH), .W(OW)) u_opwq (.clk(REF_CLK), .srst(SRST),
    .q(outbound_posted_write_queue));
  ppbd_queue #(.DEPTH(ppbd_pkg::OBUF_DEPTH), .W(OW)) u_obuf (.clk(REF_CLK), .srst(SRST),
    .q(obuf));
  ppbd_queue #(.DEPTH(ppbd_pkg::ORQ_DEPTH), .W(32)) u_orq (.clk(REF_CLK), .srst(SRST),
    .q(outbound_read_queue));
  ppbd_queue #(.DEPTH(ppbd_pkg::IPWQ_DEPTH), .W(IW)) u_ipwq (.clk(REF_CLK), .srst(SRST),
    .q(inbound_posted_write_queue));
  ppbd_queue #(.DEPTH(ppbd_pkg::IPQ_DEPTH), .W(32)) u_ipq (.clk(REF_CLK), .srst(SRST),
    .q(inbound_prefetch_queue));

  // ************************************************************
  // outbound state
  // ************************************************************
  ppbd_pkg::ppbd_ob_e ob_state_reg;
  ppbd_pkg::ppbd_ob_e ob_state_next;
  logic [7:0] wr_cnt_reg; // writes queued but not yet acknowledged on pci
  logic [3:0] ob_left_reg; // read words still due from pci
  logic [31:0] ob_exp_reg; // address the read queue head belongs to
  logic ob_cfg_reg; // read queue holds config data
  logic qb_ack_reg;

  // ************************************************************
  // outbound decode
  // ************************************************************
  wire ob_idle = (ob_state_reg == ppbd_pkg::OB_IDLE);
  // ack cycle is skipped: the master still shows the finished request
  wire ob_claim = QB_REQ && !QB_BRIDGE_CHIP_SELECT_N && !qb_ack_reg && ob_idle;
  wire ob_posted = IMG_POSTED[QB_IMAGE_SELECT] && !QB_CONFIG_DATA_WINDOW;
  wire img_io = IMG_IO[QB_IMAGE_SELECT];
  wire [1:0] ob_cmd = QB_CONFIG_DATA_WINDOW ? ppbd_pkg::CMD_CFG :
                      (img_io ? ppbd_pkg::CMD_IO : ppbd_pkg::CMD_MEM);
  wire wr_idle = (wr_cnt_reg == '0);
  wire ob_post_acc = ob_claim && QB_WR && ob_posted &&
                     outbound_posted_write_queue.push_ready;
  // delayed write waits for all earlier writes, then blocks later ones
  wire ob_dly_acc = ob_claim && QB_WR && !ob_posted && wr_idle;
  wire orq_hit = outbound_read_queue.pop_valid && QB_ADDR == ob_exp_reg &&
                 QB_CONFIG_DATA_WINDOW == ob_cfg_reg;
  wire ob_serve = ob_claim && !QB_WR && orq_hit;
  wire ob_fetch = ob_claim && !QB_WR && !orq_hit && wr_idle;
  wire dly_done = (ob_state_reg == ppbd_pkg::OB_DWWAIT) && PM_WACK &&
                  wr_cnt_reg == ppbd_pkg::WCNT_ONE;
  wire ob_rd_last = PM_RVALID && ob_left_reg == ppbd_pkg::OB_LAST;
  wire ob_push = ob_post_acc || ob_dly_acc;
  ppbd_pkg::ppbd_owe_s ob_entry;
  ppbd_pkg::ppbd_owe_s obuf_head;
  assign ob_entry = {ob_dly_acc, ob_cmd, QB_ADDR, QB_WDATA};
  assign obuf_head = obuf.pop_data;

  assign outbound_posted_write_queue.push_valid = ob_push;
  assign outbound_posted_write_queue.push_data = ob_entry;
  assign outbound_posted_write_queue.flush = 1'b0;
  assign outbound_posted_write_queue.pop_ready = obuf.push_ready; // stall reaches queue
  assign obuf.push_valid = outbound_posted_write_queue.pop_valid;
  assign obuf.push_data = outbound_posted_write_queue.pop_data;
  assign obuf.pop_ready = PM_WREADY;
  assign obuf.flush = 1'b0;
  // any write or new fetch makes prefetched data stale
  assign outbound_read_queue.flush = ob_fetch || ob_push;
  assign outbound_read_queue.push_valid = PM_RVALID && ob_state_reg == ppbd_pkg::OB_RDWAIT;
  assign outbound_read_queue.push_data = PM_RDATA;
  assign outbound_read_queue.pop_ready = ob_serve;

  // outbound sequencing
  always_comb begin
    ob_state_next = ob_state_reg;
    case (ob_state_reg)
      ppbd_pkg::OB_IDLE: begin
        if (ob_dly_acc) begin
          ob_state_next = ppbd_pkg::OB_DWWAIT;
        end else if (ob_fetch) begin
          ob_state_next = ppbd_pkg::OB_RDWAIT;
        end
      end
      ppbd_pkg::OB_RDWAIT: begin
        if (ob_rd_last) begin
          ob_state_next = ppbd_pkg::OB_IDLE;
        end
      end
      ppbd_pkg::OB_DWWAIT: begin
        if (dly_done) begin
          ob_state_next = ppbd_pkg::OB_IDLE;
        end
      end
      default: ob_state_next = ppbd_pkg::OB_IDLE;
    endcase
  end

  // outbound control registers
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ob_state_reg <= ppbd_pkg::OB_IDLE;
      wr_cnt_reg <= '0;
      qb_ack_reg <= 1'b0;
      PM_RREQ <= 1'b0;
    end else begin
      ob_state_reg <= ob_state_next;
      wr_cnt_reg <= wr_cnt_reg + 8'(ob_push) - 8'(PM_WACK);
      qb_ack_reg <= ob_post_acc || ob_serve || dly_done;
      PM_RREQ <= ob_fetch;
    end
  end

  // outbound read bookkeeping and pci read request fields
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ob_left_reg <= '0;
      ob_exp_reg <= '0;
      ob_cfg_reg <= 1'b0;
      QB_RDATA <= '0;
      PM_RCMD <= ppbd_pkg::CMD_MEM;
      PM_RADDR <= '0;
      PM_RLEN <= '0;
    end else if (ob_fetch) begin
      ob_left_reg <= QB_CONFIG_DATA_WINDOW ? ppbd_pkg::CFG_LEN : ppbd_pkg::ORQ_LEN;
      ob_exp_reg <= QB_ADDR;
      ob_cfg_reg <= QB_CONFIG_DATA_WINDOW;
      PM_RCMD <= ob_cmd;
      PM_RADDR <= QB_ADDR;
      PM_RLEN <= QB_CONFIG_DATA_WINDOW ? ppbd_pkg::CFG_LEN : ppbd_pkg::ORQ_LEN;
    end else if (ob_serve) begin
      ob_exp_reg <= ob_exp_reg + ppbd_pkg::ADDR_STEP;
      QB_RDATA <= outbound_read_queue.pop_data;
    end else if (outbound_read_queue.push_valid) begin
      ob_left_reg <= ob_left_reg - ppbd_pkg::OB_LAST;
    end
  end

  assign QB_ACK = qb_ack_reg;
  assign PM_WVALID = obuf.pop_valid;
  assign PM_WCMD = obuf_head.cmd;
  assign PM_WADDR = obuf_head.addr;
  assign PM_WDATA = obuf_head.data;

  // ************************************************************
  // inbound state and decode
  // ************************************************************
  ppbd_pkg::ppbd_ib_e ib_state_reg;
  logic [6:0] ib_left_reg;
  logic [31:0] ib_exp_reg;
  logic pt_ack_reg;
  ppbd_pkg::ppbd_iwe_s ib_entry;
  ppbd_pkg::ppbd_iwe_s ipwq_head;

  wire hit0 = ppbd_pkg::ppbd_img_hit(PT_ADDR, TIMG_BASE0, TIMG_IO[0], PT_IO);
  wire hit1 = ppbd_pkg::ppbd_img_hit(PT_ADDR, TIMG_BASE1, TIMG_IO[1], PT_IO);
  wire ib_idle = (ib_state_reg == ppbd_pkg::IB_IDLE);
  wire pt_claim = PT_REQ && (hit0 || hit1) && !pt_ack_reg && ib_idle;
  wire pt_pref = hit0 ? TIMG_PREF[0] : TIMG_PREF[1]; // image 0 wins an overlap
  wire pt_wr_acc = pt_claim && PT_WR && inbound_posted_write_queue.push_ready;
  wire ipq_hit = inbound_prefetch_queue.pop_valid && PT_ADDR == ib_exp_reg;
  wire pt_serve = pt_claim && !PT_WR && ipq_hit;
  // reads wait until earlier posted writes have left for the processor bus
  wire pt_fetch = pt_claim && !PT_WR && !ipq_hit &&
                  !inbound_posted_write_queue.pop_valid;
  wire ib_rd_last = QM_RVALID && ib_left_reg == ppbd_pkg::IB_LAST;
  assign ib_entry = {PT_ADDR, PT_WDATA};
  assign ipwq_head = inbound_posted_write_queue.pop_data;

  assign inbound_posted_write_queue.push_valid = pt_wr_acc;
  assign inbound_posted_write_queue.push_data = ib_entry;
  assign inbound_posted_write_queue.pop_ready = QM_WREADY;
  assign inbound_posted_write_queue.flush = 1'b0;
  assign inbound_prefetch_queue.flush = pt_fetch || pt_wr_acc;
  assign inbound_prefetch_queue.push_valid = QM_RVALID && !ib_idle;
  assign inbound_prefetch_queue.push_data = QM_RDATA;
  assign inbound_prefetch_queue.pop_ready = pt_serve;

  // inbound control and processor read request fields
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ib_state_reg <= ppbd_pkg::IB_IDLE;
      pt_ack_reg <= 1'b0;
      QM_RREQ <= 1'b0;
    end else begin
      ib_state_reg <= pt_fetch ? ppbd_pkg::IB_RDWAIT :
                      (ib_rd_last ? ppbd_pkg::IB_IDLE : ib_state_reg);
      pt_ack_reg <= pt_wr_acc || pt_serve;
      QM_RREQ <= pt_fetch;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ib_left_reg <= '0;
      ib_exp_reg <= '0;
      PT_RDATA <= '0;
      QM_RADDR <= '0;
      QM_RLEN <= '0;
    end else if (pt_fetch) begin
      ib_left_reg <= pt_pref ? ppbd_pkg::IPQ_LEN : ppbd_pkg::SINGLE_LEN;
      ib_exp_reg <= PT_ADDR;
      QM_RADDR <= PT_ADDR;
      QM_RLEN <= pt_pref ? ppbd_pkg::IPQ_LEN : ppbd_pkg::SINGLE_LEN;
    end else if (pt_serve) begin
      ib_exp_reg <= ib_exp_reg + ppbd_pkg::ADDR_STEP;
      PT_RDATA <= inbound_prefetch_queue.pop_data;
    end else if (inbound_prefetch_queue.push_valid) begin
      ib_left_reg <= ib_left_reg - ppbd_pkg::IB_LAST;
    end
  end

  assign PT_ACK = pt_ack_reg;
  assign QM_WVALID = inbound_posted_write_queue.pop_valid;
  assign QM_WADDR = ipwq_head.addr;
  assign QM_WDATA = ipwq_head.data;

  // ************************************************************
  // checks
  // ************************************************************
  property p_posted_ack;
    ob_post_acc |=> QB_ACK ##1 !QB_ACK;
  endproperty
  a_posted_ack: assert property (p_posted_ack) else $error("posted write not acked");

  property p_dly_ack;
    QB_ACK && $past(ob_state_reg) == ppbd_pkg::OB_DWWAIT |-> $past(PM_WACK);
  endproperty
  a_dly_ack: assert property (p_dly_ack) else $error("delayed write acked early");

  property p_dly_blocks;
    ob_state_reg == ppbd_pkg::OB_DWWAIT |-> !outbound_posted_write_queue.push_valid;
  endproperty
  a_dly_blocks: assert property (p_dly_blocks) else $error("post during delayed");

  property p_hit_no_fetch;
    ob_claim && !QB_WR && orq_hit |=> !PM_RREQ && QB_ACK;
  endproperty
  a_hit_no_fetch: assert property (p_hit_no_fetch) else $error("queued read refetched");

  property p_cs_needed;
    QB_ACK |-> $past(!QB_BRIDGE_CHIP_SELECT_N);
  endproperty
  a_cs_needed: assert property (p_cs_needed) else $error("ack without chip select");

  property p_cfg_window;
    PM_RREQ |-> (PM_RCMD == ppbd_pkg::CMD_CFG) == $past(QB_CONFIG_DATA_WINDOW) &&
                PM_RLEN == ($past(QB_CONFIG_DATA_WINDOW) ? ppbd_pkg::CFG_LEN : ppbd_pkg::ORQ_LEN);
  endproperty
  a_cfg_window: assert property (p_cfg_window) else $error("config read mis-typed");

  property p_image_io;
    ob_push && !QB_CONFIG_DATA_WINDOW |->
      (ob_entry.cmd == ppbd_pkg::CMD_IO) == (QB_IMAGE_SELECT ? IMG_IO[1] : IMG_IO[0]);
  endproperty
  a_image_io: assert property (p_image_io) else $error("wrong image space");

  property p_in_post;
    pt_wr_acc |=> PT_ACK ##1 !PT_ACK;
  endproperty
  a_in_post: assert property (p_in_post) else $error("pci write not acked");

  property p_in_delay;
    ib_state_reg == ppbd_pkg::IB_RDWAIT |-> !PT_ACK;
  endproperty
  a_in_delay: assert property (p_in_delay) else $error("pci ack before read done");

  property p_in_len;
    pt_fetch |=> QM_RREQ && QM_RLEN == ($past(pt_pref) ? ppbd_pkg::IPQ_LEN : ppbd_pkg::SINGLE_LEN);
  endproperty
  a_in_len: assert property (p_in_len) else $error("bad inbound read length");

  property p_post_cfg;
    ob_claim && QB_WR |-> ob_post_acc |-> IMG_POSTED[QB_IMAGE_SELECT] && !QB_CONFIG_DATA_WINDOW;
  endproperty
  a_post_cfg: assert property (p_post_cfg) else $error("write posted wrongly");

  property p_reset_clean;
    $fell(SRST) |-> ob_idle && ib_idle && !PM_WVALID && !QM_WVALID && !QB_ACK && !PT_ACK;
  endproperty
  a_reset_clean: assert property (p_reset_clean) else $error("state left after reset");

  // back-to-back posts: the ack cycle is blind, so a repeat comes two or three later
  cover property (ob_post_acc ##[2:3] ob_post_acc);
  cover property (dly_done);
  cover property (ob_serve);
  cover property (pt_fetch && pt_pref);
endmodule

// ===== testbench/ppbd_far_model.sv
/* far side model: pci master and processor master buses of the datapath.
   assumes each read request is followed by exactly its length of words. */
`timescale 1ns/1ps
module ppbd_far_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic hold,
  input wire logic pm_wvalid,
  output logic pm_wready,
  output logic pm_wack,
  input wire logic pm_rreq,
  input wire logic [31:0] pm_raddr,
  input wire logic [3:0] pm_rlen,
  output logic pm_rvalid,
  output logic [31:0] pm_rdata,
  output logic qm_wready,
  input wire logic qm_rreq,
  input wire logic [31:0] qm_raddr,
  input wire logic [6:0] qm_rlen,
  output logic qm_rvalid,
  output logic [31:0] qm_rdata
);
  logic slow_reg; // answers only every other cycle
  logic [31:0] pa_reg, qa_reg; // next read address
  logic [6:0] pn_reg, qn_reg; // words still owed
  wire pgo = slow_reg && pn_reg != 7'h00;
  wire qgo = slow_reg && qn_reg != 7'h00;
  // idle data lines flip each cycle between the last word and its inverse
  always_ff @(posedge clk) begin
    slow_reg <= !srst && !slow_reg;
    pm_wready <= !srst && !hold && slow_reg;
    qm_wready <= !srst && slow_reg;
    pm_wack <= !srst && pm_wvalid && pm_wready;
    pm_rvalid <= !srst && pgo;
    qm_rvalid <= !srst && qgo;
    pm_rdata <= pgo ? pa_reg ^ 32'h5a5a_0000 : ~pm_rdata;
    qm_rdata <= qgo ? qa_reg ^ 32'h0000_a5a5 : ~qm_rdata;
    pa_reg <= pm_rreq ? pm_raddr : pa_reg + (pgo ? 32'h4 : 32'h0);
    qa_reg <= qm_rreq ? qm_raddr : qa_reg + (qgo ? 32'h4 : 32'h0);
    pn_reg <= srst ? 7'h00 : pm_rreq ? {3'h0, pm_rlen} : pn_reg - {6'h00, pgo};
    qn_reg <= srst ? 7'h00 : qm_rreq ? qm_rlen : qn_reg - {6'h00, qgo};
  end
endmodule

// ===== testbench/ppbd_top_bench.sv
/* self-checking bench of ppbd_top with the far side model.
   assumes the package, queue carrier and design files compile first. */
`timescale 1ns/1ps
module ppbd_top_bench;
  typedef struct packed {
    logic [3:0] k; // write, select_n, config, image
    logic [31:0] addr, dat; // address, write or read data
    logic ack; // answer expected
  } ppbd_row_s;
  logic REF_CLK = 1'h0, SRST = 1'h1, QB_REQ = 1'h0, QB_BRIDGE_CHIP_SELECT_N = 1'h1;
  logic QB_CONFIG_DATA_WINDOW = 1'h0, QB_IMAGE_SELECT = 1'h0, QB_WR = 1'h0;
  logic [31:0] QB_ADDR = 32'h0, QB_WDATA = 32'h0, PT_ADDR = 32'h0, PT_WDATA = 32'h0;
  logic [1:0] IMG_POSTED = 2'h1, IMG_IO = 2'h2, TIMG_IO = 2'h2, TIMG_PREF = 2'h1;
  logic PT_REQ = 1'h0, PT_WR = 1'h0, PT_IO = 1'h0, hold = 1'h0, got;
  logic [31:0] TIMG_BASE0 = 32'h8000_0000, TIMG_BASE1 = 32'h9000_0000;
  logic QB_ACK, PM_WVALID, PM_WREADY, PM_WACK, PM_RREQ, PM_RVALID, PT_ACK;
  logic QM_WVALID, QM_WREADY, QM_RREQ, QM_RVALID;
  logic [1:0] PM_WCMD, PM_RCMD;
  logic [3:0] PM_RLEN;
  logic [6:0] QM_RLEN, qlen;
  logic [31:0] QB_RDATA, PM_WADDR, PM_WDATA, PM_RADDR, PM_RDATA, PT_RDATA;
  logic [31:0] QM_WADDR, QM_WDATA, QM_RADDR, QM_RDATA;
  logic [65:0] wq[$], qq[$]; // words seen leaving on each bus
  int failures = 0, num_checks = 0, cyc = 0, wacks = 0, rreqs = 0, k;
  ppbd_row_s rows[7] = '{'{4'h8, 32'h1000, 32'h11, 1'h1}, '{4'h9, 32'h2000, 32'h22, 1'h1},
    '{4'hc, 32'h2004, 32'h33, 1'h0}, '{4'h0, 32'h3000, 32'h5a5a_3000, 1'h1},
    '{4'h0, 32'h3004, 32'h5a5a_3004, 1'h1}, '{4'h2, 32'h3008, 32'h5a5a_3008, 1'h1},
    '{4'ha, 32'h3010, 32'h44, 1'h1}};

  ppbd_top i_ppbd_top (.*);
  ppbd_far_model i_ppbd_far_model (.clk(REF_CLK), .srst(SRST), .hold(hold),
    .pm_wvalid(PM_WVALID), .pm_wready(PM_WREADY), .pm_wack(PM_WACK), .pm_rreq(PM_RREQ),
    .pm_raddr(PM_RADDR), .pm_rlen(PM_RLEN), .pm_rvalid(PM_RVALID), .pm_rdata(PM_RDATA),
    .qm_wready(QM_WREADY), .qm_rreq(QM_RREQ), .qm_raddr(QM_RADDR), .qm_rlen(QM_RLEN),
    .qm_rvalid(QM_RVALID), .qm_rdata(QM_RDATA));

  always #12.5 REF_CLK = !REF_CLK;

  // bus monitor and hang guard
  always @(posedge REF_CLK) begin
    cyc++;
    if (PM_WVALID && PM_WREADY) wq.push_back({PM_WCMD, PM_WADDR, PM_WDATA});
    if (QM_WVALID && QM_WREADY) qq.push_back({2'h0, QM_WADDR, QM_WDATA});
    if (PM_WACK) wacks++;
    if (PM_RREQ) rreqs++;
    if (QM_RREQ) qlen = QM_RLEN;
    if (cyc > 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input logic [65:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // processor request held until the acknowledge or the wait limit
  task automatic op(input ppbd_row_s r, input int lim);
    int n = 0;
    @(posedge REF_CLK);
    {QB_WR, QB_BRIDGE_CHIP_SELECT_N, QB_CONFIG_DATA_WINDOW, QB_IMAGE_SELECT} <= r.k;
    QB_ADDR <= r.addr;
    QB_WDATA <= r.dat;
    QB_REQ <= 1'h1;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (QB_ACK !== 1'h1 && n < lim);
    got = QB_ACK;
    QB_REQ <= 1'h0;
    QB_BRIDGE_CHIP_SELECT_N <= 1'h1;
  endtask

  // pci target request: kind is request, write, io
  task automatic pt(input logic [2:0] kind, input logic [31:0] a, d);
    int n = 0;
    @(posedge REF_CLK);
    {PT_REQ, PT_WR, PT_IO} <= kind;
    PT_ADDR <= a;
    PT_WDATA <= d;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PT_ACK !== 1'h1 && n < 300);
    got = PT_ACK;
    PT_REQ <= 1'h0;
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge REF_CLK);
    SRST <= 1'h0;
    foreach (rows[i]) begin
      op(rows[i], 60);
      chk(got, rows[i].ack);
      if (i == 1 || i == 6) chk(wacks, wq.size());
      if (!rows[i].k[3] && got) chk(QB_RDATA, rows[i].dat);
    end
    chk(rreqs, 2);
    chk(PM_RCMD, ppbd_pkg::CMD_CFG);
    chk(wq[0], {ppbd_pkg::CMD_MEM, 64'h0000_1000_0000_0011});
    chk(wq[1], {ppbd_pkg::CMD_IO, 64'h0000_2000_0000_0022});
    chk(wq[2], {ppbd_pkg::CMD_CFG, 64'h0000_3010_0000_0044});
    // stalled far side: post until refused, then drain in order
    wq.delete();
    hold <= 1'h1;
    k = 0;
    got = 1'h1;
    while (got === 1'h1) begin
      op('{4'h8, 32'h4000 + 32'(k * 4), 32'(k), 1'h1}, 12);
      k += int'(got);
    end
    chk(k, ppbd_pkg::OPWQ_DEPTH + ppbd_pkg::OBUF_DEPTH);
    hold <= 1'h0;
    for (int n = 0; n < 600 && wq.size() < k; n++) @(posedge REF_CLK);
    chk(wq.size(), k);
    foreach (wq[i]) chk(wq[i][31:0], i);
    // reset drops the prefetched words
    op('{4'h0, 32'h5000, 32'h5a5a_5000, 1'h1}, 60);
    k = rreqs;
    SRST <= 1'h1;
    repeat (2) @(posedge REF_CLK);
    SRST <= 1'h0;
    op('{4'h0, 32'h5004, 32'h5a5a_5004, 1'h1}, 60);
    chk(QB_RDATA, 32'h5a5a_5004);
    chk(rreqs, k + 1);
    // pci target side
    pt(3'h6, 32'h8000_0010, 32'h77);
    chk(got, 1'h1);
    pt(3'h4, 32'h8000_0100, 32'h0);
    chk(PT_RDATA, 32'h8000_a4a5);
    chk(qlen, ppbd_pkg::IPQ_LEN);
    pt(3'h5, 32'h9000_0000, 32'h0);
    chk(qlen, ppbd_pkg::SINGLE_LEN);
    pt(3'h4, 32'h7000_0000, 32'h0);
    chk(got, 1'h0);
    chk(qq[0], {34'h0_8000_0010, 32'h77});
    end_sim();
  end
endmodule
